//--- common/asps_defs.svh
// Register offsets, field positions and reset values of the alarm status block.
`ifndef ASPS_DEFS_SVH
`define ASPS_DEFS_SVH

// Byte offsets on the serial configuration port.
`define ASPS_OFS_IRQ_ENABLE   16'h0079
`define ASPS_OFS_STICKY       16'h0200
`define ASPS_OFS_STICKY_RSVD  16'h0201
`define ASPS_OFS_REF_STATUS   16'h0202
`define ASPS_OFS_LOCK_STATE   16'h0203

// Bit positions shared by the sticky byte and the enable byte.
`define ASPS_BIT_LOCK_LOSS    6
`define ASPS_BIT_HOLDOVER     4
`define ASPS_BIT_REF1_LOSS    1
`define ASPS_BIT_REF0_LOSS    0

// Bit positions of the live loop status bytes.
`define ASPS_BIT_NO_REF       3
`define ASPS_BIT_LOCKED       4
// Top bit of the selected reference code and of the loop state code.
`define ASPS_REF_CODE_MSB     2
`define ASPS_STATE_CODE_MSB   1

// Reset values and the zero byte used for reserved and unmapped reads.
`define ASPS_STICKY_RESET     4'h0
`define ASPS_ENABLE_RESET     4'h0
`define ASPS_BYTE_ZERO        8'h00

`endif

//--- common/asps_pkg.sv
// Types shared by the alarm sticky status and loop state block.
package asps_pkg;
    // One byte of register data.
    typedef logic [7:0]  asps_byte_t;
    // Register address on the serial configuration port.
    typedef logic [15:0] asps_addr_t;
    // Four tracked alarms: lock loss, holdover, ref1 loss, ref0 loss.
    typedef logic [3:0]  asps_alarm_t;
    // Selected reference code of the loop.
    typedef logic [2:0]  asps_ref_code_t;
    // Loop state code: 01 free-run, 10 tracking, 11 holdover.
    typedef logic [1:0]  asps_state_code_t;
endpackage

//--- logic/asps_status.sv
// Alarm sticky flags, interrupt enables and live loop status registers.
//
// Notes on behaviour
// - Any tracked alarm sets its sticky bit.
// - Sticky bit holds until software clears it.
// - Write one clears, zero keeps, reads current.
// - Lock loss sticky at bit 6, byte 0200.
// - Holdover sticky at bit 4, byte 0200.
// - Reference loss stickies at bits 1 and 0.
// - Loop status bytes show live state unlatched.
// - Live fields are not one snapshot.
// - No-reference flag high when none is valid.
// - Selected reference code 100, 101, else none.
// - Lock indicator below threshold, never in synthesizer.
// - Loop state code 01, 10, 11.
// - Enable bit gates each sticky onto interrupt.
// - Interrupt low one cycle after any enabled sticky set.
`timescale 1ns/1ns
`include "asps_defs.svh"

module asps_status (
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    input  wire asps_pkg::asps_addr_t      reg_addr,
    input  wire logic                      reg_wr,
    input  wire asps_pkg::asps_byte_t      reg_wdata,
    input  wire logic                      reg_rd,
    input  wire logic                      lock_loss_alarm,
    input  wire logic                      holdover_alarm,
    input  wire logic                      ref0_loss_alarm,
    input  wire logic                      ref1_loss_alarm,
    input  wire logic                      no_valid_ref,
    input  wire asps_pkg::asps_ref_code_t  selected_reference_code,
    input  wire logic                      phase_error_below_limit,
    input  wire logic                      synth_mode,
    input  wire asps_pkg::asps_state_code_t loop_state_code,
    output logic                           reg_rvalid,
    output asps_pkg::asps_byte_t           reg_rdata,
    output logic                           irq_out_n
);
    import asps_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Address decode and write data routing.

    // Register selects, one per mapped byte.
    wire logic        sel_enable;
    wire logic        sel_sticky;
    wire logic        sel_ref_status;
    wire logic        sel_lock_state;
    // Write strobes; the live status bytes get none, so writes there die.
    wire logic        wr_enable;
    wire logic        wr_sticky;
    // Incoming alarms packed in sticky order.
    wire asps_alarm_t alarm_evt;
    // Write data bits that land on the four tracked positions.
    wire asps_alarm_t wdata_bits;
    // Live lock indication.
    wire logic        loop_locked;

    assign sel_enable      = (reg_addr == `ASPS_OFS_IRQ_ENABLE);
    assign sel_sticky      = (reg_addr == `ASPS_OFS_STICKY);
    assign sel_ref_status  = (reg_addr == `ASPS_OFS_REF_STATUS);
    assign sel_lock_state  = (reg_addr == `ASPS_OFS_LOCK_STATE);
    assign wr_enable       = reg_wr & sel_enable;
    assign wr_sticky       = reg_wr & sel_sticky;

    assign alarm_evt  = {lock_loss_alarm, holdover_alarm,
                         ref1_loss_alarm, ref0_loss_alarm};
    // Reserved bits of the written byte are ignored, whatever software sends.
    assign wdata_bits = {reg_wdata[`ASPS_BIT_LOCK_LOSS],
                         reg_wdata[`ASPS_BIT_HOLDOVER],
                         reg_wdata[`ASPS_BIT_REF1_LOSS],
                         reg_wdata[`ASPS_BIT_REF0_LOSS]};

    assign loop_locked = phase_error_below_limit & ~synth_mode;

    ////////////////////////////////////////////////////////////////////////
    // Sticky alarm flags and interrupt enables.

    // Sticky flags: [3] lock loss, [2] holdover, [1] ref1, [0] ref0.
    asps_alarm_t sticky_q;
    asps_alarm_t sticky_d;
    // Interrupt enables in the same order.
    asps_alarm_t enable_q;
    asps_alarm_t enable_d;
    // Bits that software clears this cycle.
    wire asps_alarm_t clear_bits;

    assign clear_bits = wr_sticky ? wdata_bits : `ASPS_STICKY_RESET;
    assign sticky_d   = (sticky_q & ~clear_bits) | alarm_evt;
    assign enable_d   = wr_enable ? wdata_bits : enable_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sticky_q <= `ASPS_STICKY_RESET;
            enable_q <= `ASPS_ENABLE_RESET;
        end else begin
            sticky_q <= sticky_d;
            enable_q <= enable_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt output.

    // Enabled sticky bits; the output lags the flags by one cycle.
    wire logic irq_pending;

    assign irq_pending = |(sticky_q & enable_q);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~irq_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data assembly.

    // Assembled bytes; reserved bits read zero.
    asps_byte_t byte_sticky;
    asps_byte_t byte_enable;
    asps_byte_t byte_ref;
    asps_byte_t byte_lock;
    wire asps_byte_t read_mux;

    always_comb begin
        byte_sticky = `ASPS_BYTE_ZERO;
        byte_sticky[`ASPS_BIT_LOCK_LOSS] = sticky_q[3];
        byte_sticky[`ASPS_BIT_HOLDOVER]  = sticky_q[2];
        byte_sticky[`ASPS_BIT_REF1_LOSS] = sticky_q[1];
        byte_sticky[`ASPS_BIT_REF0_LOSS] = sticky_q[0];
        byte_enable = `ASPS_BYTE_ZERO;
        byte_enable[`ASPS_BIT_LOCK_LOSS] = enable_q[3];
        byte_enable[`ASPS_BIT_HOLDOVER]  = enable_q[2];
        byte_enable[`ASPS_BIT_REF1_LOSS] = enable_q[1];
        byte_enable[`ASPS_BIT_REF0_LOSS] = enable_q[0];
    end

    // fields sampled apart
    // Fields are taken separately, so a read during a change may mix them.
    always_comb begin
        byte_ref = `ASPS_BYTE_ZERO;
        byte_ref[`ASPS_BIT_NO_REF] = no_valid_ref;
        byte_ref[`ASPS_REF_CODE_MSB:0] = selected_reference_code;
        byte_lock = `ASPS_BYTE_ZERO;
        byte_lock[`ASPS_BIT_LOCKED] = loop_locked;
        byte_lock[`ASPS_STATE_CODE_MSB:0] = loop_state_code;
    end

    // Unmapped and reserved addresses read zero.
    assign read_mux = sel_sticky     ? byte_sticky :
                      sel_enable     ? byte_enable :
                      sel_ref_status ? byte_ref    :
                      sel_lock_state ? byte_lock   : `ASPS_BYTE_ZERO;

    // Read answer one cycle after the request; the byte holds until the next.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata  <= `ASPS_BYTE_ZERO;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= read_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions and cover points.

    property p_alarm_sets;
        @(posedge clock) disable iff (sys_rst)
        lock_loss_alarm |=> sticky_q[3];
    endproperty
    a_alarm_sets: assert property (p_alarm_sets)
        else $error("lock loss alarm did not set its flag");

    property p_flag_holds;
        @(posedge clock) disable iff (sys_rst)
        (sticky_q[2] && !(wr_sticky && reg_wdata[`ASPS_BIT_HOLDOVER]))
        |=> sticky_q[2];
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("holdover flag dropped without a clear");

    property p_clear_one;
        @(posedge clock) disable iff (sys_rst)
        (wr_sticky && reg_wdata[`ASPS_BIT_REF0_LOSS] && !ref0_loss_alarm)
        |=> !sticky_q[0];
    endproperty
    a_clear_one: assert property (p_clear_one)
        else $error("write one did not clear ref0 flag");

    property p_read_sticky;
        @(posedge clock) disable iff (sys_rst)
        (reg_rd && sel_sticky) |=>
        reg_rvalid && reg_rdata[`ASPS_BIT_LOCK_LOSS] == $past(sticky_q[3])
        && reg_rdata[`ASPS_BIT_REF1_LOSS] == $past(sticky_q[1]);
    endproperty
    a_read_sticky: assert property (p_read_sticky)
        else $error("sticky byte read back wrong");

    property p_set_wins;
        @(posedge clock) disable iff (sys_rst)
        (wr_sticky && reg_wdata[`ASPS_BIT_HOLDOVER] && holdover_alarm)
        |=> sticky_q[2];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a same cycle holdover alarm");

    property p_lock_live;
        @(posedge clock) disable iff (sys_rst)
        (reg_rd && sel_lock_state) |=>
        reg_rdata[`ASPS_BIT_LOCKED] ==
        $past(phase_error_below_limit && !synth_mode)
        && reg_rdata[1:0] == $past(loop_state_code);
    endproperty
    a_lock_live: assert property (p_lock_live)
        else $error("lock byte does not follow the loop");

    property p_ref_live;
        @(posedge clock) disable iff (sys_rst)
        (reg_rd && sel_ref_status) |=>
        reg_rdata[`ASPS_BIT_NO_REF] == $past(no_valid_ref)
        && reg_rdata[2:0] == $past(selected_reference_code);
    endproperty
    a_ref_live: assert property (p_ref_live)
        else $error("reference byte does not follow the loop");

    property p_irq_low;
        @(posedge clock) disable iff (sys_rst)
        (|(sticky_q & enable_q)) |=> !irq_out_n;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("interrupt not asserted for enabled flag");

    property p_irq_masked;
        @(posedge clock) disable iff (sys_rst)
        (enable_q == `ASPS_ENABLE_RESET) |=> irq_out_n;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt asserted with all enables off");

    property p_status_write_ignored;
        @(posedge clock) disable iff (sys_rst)
        (reg_wr && (sel_ref_status || sel_lock_state) && !(|alarm_evt))
        |=> $stable(sticky_q) && $stable(enable_q);
    endproperty
    a_status_write_ignored: assert property (p_status_write_ignored)
        else $error("write to status byte changed a register");

    c_clear: cover property (@(posedge clock) disable iff (sys_rst)
        sticky_q[3] ##1 wr_sticky ##1 !sticky_q[3]);
    c_irq: cover property (@(posedge clock) disable iff (sys_rst)
        irq_out_n ##1 !irq_out_n);
    c_collide: cover property (@(posedge clock) disable iff (sys_rst)
        wr_sticky && reg_wdata[`ASPS_BIT_HOLDOVER] && holdover_alarm);
    c_lock_read: cover property (@(posedge clock) disable iff (sys_rst)
        reg_rvalid && reg_rdata[`ASPS_BIT_LOCKED]);
endmodule

//--- bench/asps_host.sv
// Host model that issues register accesses over the configuration port.
`timescale 1ns/1ns
module asps_host (
    input  wire logic                 clock,
    input  wire logic                 reg_rvalid,
    input  wire asps_pkg::asps_byte_t reg_rdata,
    output asps_pkg::asps_addr_t      reg_addr,
    output logic                      reg_wr,
    output asps_pkg::asps_byte_t      reg_wdata,
    output logic                      reg_rd
);
    import asps_pkg::*;
    asps_byte_t last_rd_q; // Byte taken from the last read answer.

    // Idle port at time zero.
    initial begin
        {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One access a cycle; strobes stay until the next call changes them.
    // reserved bits zero
    task automatic xfer(input logic r, input logic w, input asps_addr_t a,
                        input asps_byte_t d);
        reg_rd    = r;
        reg_wr    = w;
        reg_addr  = a;
        // Reserved positions always go out as zero; the read-only bytes
        // keep their field bits so that ignored writes still carry data.
        case (a)
            16'h0079, 16'h0200: reg_wdata = d & 8'h53;
            16'h0202:           reg_wdata = d & 8'h0f;
            16'h0203:           reg_wdata = d & 8'h13;
            default:            reg_wdata = 8'h00;
        endcase
        @(posedge clock);
        #1;
    endtask

    always @(posedge clock) begin
        if (reg_rvalid) begin
            last_rd_q <= reg_rdata;
        end
    end
endmodule

//--- bench/testbench.sv
// Self-checking testbench for the alarm sticky status block.
`timescale 1ns/1ns
module testbench;
    import asps_pkg::*;
    logic             clock = 0;
    logic             sys_rst = 1;
    asps_addr_t       reg_addr;
    asps_byte_t       reg_wdata, reg_rdata;
    logic             reg_wr, reg_rd, reg_rvalid, irq_out_n;
    logic [3:0]       al = 0; // Alarms: lock, holdover, ref1, ref0.
    logic             nvr = 0, ple = 0, syn = 0;
    asps_ref_code_t   code = 0;
    asps_state_code_t stc = 0;
    int               n_fail = 0, n_tests = 0, seed = 32'hfb0d, i;
    bit               quiet = 1, irq_e = 1, rv_e = 0;
    asps_byte_t       stk, en, hold_e, rdq[$]; // Model state, held byte, reads.
    asps_addr_t       adr[6] = '{16'h0079, 16'h0200, 16'h0201,
                                 16'h0202, 16'h0203, 16'h0204};

    always #4 clock = ~clock;

    asps_status DUT (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .lock_loss_alarm(al[3]), .holdover_alarm(al[2]),
        .ref1_loss_alarm(al[1]), .ref0_loss_alarm(al[0]),
        .no_valid_ref(nvr), .selected_reference_code(code),
        .phase_error_below_limit(ple), .synth_mode(syn),
        .loop_state_code(stc), .reg_rvalid(reg_rvalid),
        .reg_rdata(reg_rdata), .irq_out_n(irq_out_n));

    asps_host host (.clock(clock), .reg_rvalid(reg_rvalid),
        .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd));

    // Expected read byte from the model; live bytes come straight in.
    function automatic asps_byte_t rdval(asps_addr_t a);
        case (a)
            16'h0079: return en;
            16'h0200: return stk;
            16'h0202: return {4'h0, nvr, code};
            16'h0203: return {3'h0, ple & ~syn, 2'h0, stc};
            default:  return 8'h00;
        endcase
    endfunction

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Model: reads see pre-write state, interrupt lags the flags by one.
    always @(posedge clock) begin
        if (sys_rst) begin
            {stk, en, irq_e, rv_e} = 18'h00001 << 1;
            rdq.delete();
            hold_e = 8'h00;
        end else begin
            rv_e = reg_rd;
            if (reg_rd) rdq.push_back(rdval(reg_addr));
            irq_e = !(|(stk & en));
            if (reg_wr && reg_addr == 16'h0200) stk = stk & ~reg_wdata;
            if (reg_wr && reg_addr == 16'h0079) en = reg_wdata & 8'h53;
            stk = stk | {1'b0, al[3], 1'b0, al[2], 2'h0, al[1:0]};
        end
    end

    // Compare every result mid-cycle, where outputs have settled.
    always @(negedge clock) begin
        if ($time > 10) begin
            check("irq_out_n", irq_out_n, irq_e);
            check("reg_rvalid", reg_rvalid, rv_e);
            // The read byte must also stand unchanged until the next answer.
            if (reg_rvalid === 1'b1 && rdq.size() > 0)
                hold_e = rdq.pop_front();
            check("reg_rdata", reg_rdata, hold_e);
        end
    end

    // Alarms come in bursts, live loop status changes every cycle.
    always @(posedge clock) begin
        #1;
        al = quiet ? 4'h0 : 4'($random(seed) & $random(seed) & $random(seed));
        {nvr, ple, syn, code, stc} = 8'($random(seed));
    end

    initial begin
        repeat (12) @(posedge clock);
        #1 sys_rst = 0;
        for (i = 0; i < 6; i++) host.xfer(1, 0, adr[i], 0);
        host.xfer(0, 1, 16'h0079, 8'hff);
        for (i = 0; i < 900; i++) begin
            quiet = i[4];
            if (i == 500) sys_rst = 1;
            if (i == 502) sys_rst = 0;
            host.xfer(1'($random(seed)), 1'($random(seed)),
                      adr[{$random(seed)} % 6], 8'($random(seed)));
        end
        host.xfer(0, 0, 0, 0);
        repeat (3) @(posedge clock);
        wrap_up;
    end

    // Watchdog well beyond the expected run length.
    initial begin
        #100000;
        n_fail++;
        wrap_up;
    end
endmodule
